// [common/cqf_consts.svh]
// Constants for the charge quota and fault control block.
// Assumes it is included by bare name wherever offsets or counts are needed.
// Behaviour
// - Accumulate and act only in Active state.
// - Attach or removal keeps charge and state.
// - Removal then attach below limit restarts emulation.
// - Normal operation until threshold is reached.
// - Behaviour writes leave accumulated charge alone.
// - Pre-threshold behaviour change is silent.
// - Post-threshold behaviour change applies at once.
// - From Ignore: alert, disconnect or sleep.
// - From Report: release, disconnect or sleep.
// - From Report+Disconnect: release, recheck pins, sleep.
// - From Sleep: recheck, alert, disconnect with switches open.
// - Disable before threshold clears accumulated charge.
// - Disable after threshold clears flag, rechecks inputs.
// - Writing clear resets accumulated charge to zero.
// - Clear before threshold just restarts accumulation.
// - Clear after threshold performs behaviour reset actions.
// - Latched and auto-recovery fault handling modes.
// - Fault mode from config bit or latch pin.
// - Six fault causes recognised.
// - Behaviour encoding 00 Report, 01 default, 10, 11.
// - Reset actions per behaviour after threshold.
// - Recheck restarts emulation only if inputs changed.
`ifndef CQF_CONSTS_SVH
`define CQF_CONSTS_SVH
// ****************************************
// Register offsets
// ****************************************
`define CQF_OFS_SWITCH_CFG 8'h17
`define CQF_OFS_QUOTA_CFG 8'h25
`define CQF_OFS_STATUS 8'h26
`define CQF_OFS_THR_HI 8'h27
`define CQF_OFS_THR_LO 8'h28
`define CQF_OFS_ACC_HI 8'h29
`define CQF_OFS_ACC_LO 8'h2A
// ****************************************
// Field positions and reset values
// ****************************************
`define CQF_POS_LATCH_SET 0
`define CQF_POS_BEH_LO 0
`define CQF_POS_QUOTA_EN 2
`define CQF_POS_QUOTA_CLR 3
`define CQF_POS_ST_HIT 0
`define CQF_POS_ST_FAULT 1
`define CQF_RST_SWITCH_CFG 8'h00
`define CQF_RST_BEH 2'h1
`define CQF_RST_THR 16'hFFFF
`define CQF_ACC_ZERO 16'h0000
`endif

// [common/cqf_pkg.sv]
// Types shared by the charge quota and fault control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package cqf_pkg;
  // Behaviour field encoding
  typedef enum logic [1:0] {
    CQF_BEH_REPORT = 2'h0,
    CQF_BEH_REPDISC = 2'h1,
    CQF_BEH_SLEEP = 2'h2,
    CQF_BEH_IGNORE = 2'h3
  } cqf_beh_t;
  // Applied rationing state, one-hot
  typedef enum logic [4:0] {
    CQF_ST_NORMAL = 5'h01,
    CQF_ST_REPORT = 5'h02,
    CQF_ST_REPDISC = 5'h04,
    CQF_ST_SLEEP = 5'h08,
    CQF_ST_IGNORE = 5'h10
  } cqf_state_t;
endpackage
`default_nettype wire

// [hw/cqf_accum.sv]
// Charge accumulator with threshold compare and sticky hit flag.
// Assumes charge increments arrive as synchronous strobes.
`include "cqf_consts.svh"
`default_nettype none
module cqf_accum (
  input wire logic clk,
  input wire logic reset,
  input wire logic active_state,
  input wire logic quota_enable,
  input wire logic acc_clear,
  input wire logic charge_valid,
  input wire logic [7:0] charge_amount,
  input wire logic [15:0] threshold,
  output logic [15:0] acc_q,
  output logic hit_q
);
  logic [16:0] sum;
  logic [15:0] acc_d;

  // Saturating add so a long session never wraps below the limit
  always_comb begin
    sum = {1'b0, acc_q} + {9'h000, charge_amount};
    acc_d = acc_q;
    if (charge_valid && active_state && quota_enable && !hit_q) begin
      acc_d = sum[16] ? 16'hFFFF : sum[15:0];
    end
  end

  // Accumulator; clear or disable wins over a new increment
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_q <= `CQF_ACC_ZERO;
    end else if (acc_clear || !quota_enable) begin
      acc_q <= `CQF_ACC_ZERO;
    end else begin
      acc_q <= acc_d;
    end
  end

  // Sticky hit flag, removed only by clear or disable
  always_ff @(posedge clk) begin
    if (reset) begin
      hit_q <= 1'b0;
    end else if (acc_clear || !quota_enable) begin
      hit_q <= 1'b0;
    end else if (active_state && acc_q >= threshold) begin
      hit_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [hw/cqf_top.sv]
// Charge quota behaviour control, fault mode selection and register file.
// Assumes synchronous inputs and a parallel register port from the SMBus slave.
`include "cqf_consts.svh"
`default_nettype none
module cqf_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic active_state,
  input wire logic charge_valid,
  input wire logic [7:0] charge_amount,
  input wire logic attach_event,
  input wire logic removal_event,
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic emulation_enable,
  input wire logic detect_feature_enable,
  input wire logic port_power_enable,
  input wire logic smbus_in_use,
  input wire logic latch_pin,
  input wire logic fault_clear,
  input wire logic flt_over_current,
  input wire logic flt_over_voltage,
  input wire logic flt_under_voltage,
  input wire logic flt_back_voltage,
  input wire logic flt_discharge,
  input wire logic flt_over_temp,
  output logic alert_n_q,
  output logic profile_remove_q,
  output logic power_switch_open_q,
  output logic bypass_block_q,
  output logic sleep_req_q,
  output logic emul_restart_q,
  output logic fault_latched_mode_q,
  output logic fault_q
);
  // ****************************************
  // Register file
  // ****************************************
  logic [7:0] switch_cfg_q;
  cqf_pkg::cqf_beh_t charge_quota_behavior_q;
  logic charge_quota_enable_q;
  logic [15:0] thr_q;
  logic clr_pulse;
  logic [15:0] acc;
  logic quota_hit_flag;
  logic hit_prev_q;
  logic wr_cfg;
  logic [1:0] beh_w;
  logic beh_change;
  logic en_fall;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction

  assign wr_cfg = reg_wr && addr_is(reg_addr, `CQF_OFS_QUOTA_CFG);
  assign beh_w = reg_wdata[`CQF_POS_BEH_LO +: 2];
  // Clear is a write-one strobe, not stored
  assign clr_pulse = wr_cfg && reg_wdata[`CQF_POS_QUOTA_CLR];
  assign beh_change = wr_cfg && (beh_w != charge_quota_behavior_q);
  assign en_fall = wr_cfg && charge_quota_enable_q && !reg_wdata[`CQF_POS_QUOTA_EN];

  // Writable registers; behaviour write never touches the accumulator
  always_ff @(posedge clk) begin
    if (reset) begin
      switch_cfg_q <= `CQF_RST_SWITCH_CFG;
      charge_quota_behavior_q <= cqf_pkg::cqf_beh_t'(`CQF_RST_BEH);
      charge_quota_enable_q <= 1'b0;
      thr_q <= `CQF_RST_THR;
    end else if (reg_wr) begin
      if (addr_is(reg_addr, `CQF_OFS_SWITCH_CFG)) begin
        switch_cfg_q <= reg_wdata;
      end else if (wr_cfg) begin
        charge_quota_behavior_q <= cqf_pkg::cqf_beh_t'(beh_w);
        charge_quota_enable_q <= reg_wdata[`CQF_POS_QUOTA_EN];
      end else if (addr_is(reg_addr, `CQF_OFS_THR_HI)) begin
        thr_q[15:8] <= reg_wdata;
      end else if (addr_is(reg_addr, `CQF_OFS_THR_LO)) begin
        thr_q[7:0] <= reg_wdata;
      end
    end
  end

  // Read mux, registered; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
    end else if (addr_is(reg_addr, `CQF_OFS_SWITCH_CFG)) begin
      reg_rdata_q <= switch_cfg_q;
    end else if (addr_is(reg_addr, `CQF_OFS_QUOTA_CFG)) begin
      reg_rdata_q <= {5'h00, charge_quota_enable_q, charge_quota_behavior_q};
    end else if (addr_is(reg_addr, `CQF_OFS_STATUS)) begin
      reg_rdata_q <= {6'h00, fault_q, quota_hit_flag};
    end else if (addr_is(reg_addr, `CQF_OFS_THR_HI)) begin
      reg_rdata_q <= thr_q[15:8];
    end else if (addr_is(reg_addr, `CQF_OFS_THR_LO)) begin
      reg_rdata_q <= thr_q[7:0];
    end else if (addr_is(reg_addr, `CQF_OFS_ACC_HI)) begin
      reg_rdata_q <= acc[15:8];
    end else if (addr_is(reg_addr, `CQF_OFS_ACC_LO)) begin
      reg_rdata_q <= acc[7:0];
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ****************************************
  // Accumulator
  // ****************************************
  // Attach and removal events are deliberately not wired in here
  cqf_accum u_accum (
    .clk(clk),
    .reset(reset),
    .active_state(active_state),
    .quota_enable(charge_quota_enable_q),
    .acc_clear(clr_pulse),
    .charge_valid(charge_valid),
    .charge_amount(charge_amount),
    .threshold(thr_q),
    .acc_q(acc),
    .hit_q(quota_hit_flag)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      hit_prev_q <= 1'b0;
    end else begin
      hit_prev_q <= quota_hit_flag;
    end
  end

  // ****************************************
  // Control input snapshot
  // ****************************************
  logic [4:0] ctl_now;
  logic [4:0] ctl_snap_q;
  logic hit_rise;

  assign ctl_now = {mode_select_hi, mode_select_lo, emulation_enable, detect_feature_enable, port_power_enable};
  assign hit_rise = quota_hit_flag && !hit_prev_q;

  // Pins captured when the threshold is reached, for later comparison
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl_snap_q <= 5'h00;
    end else if (hit_rise) begin
      ctl_snap_q <= ctl_now;
    end
  end

  // ****************************************
  // Applied behaviour state machine
  // ****************************************
  cqf_pkg::cqf_state_t state_q;
  cqf_pkg::cqf_state_t state_d;
  logic recheck;

  function automatic cqf_pkg::cqf_state_t beh_state(input logic [1:0] b);
    case (b)
      2'h0: beh_state = cqf_pkg::CQF_ST_REPORT;
      2'h1: beh_state = cqf_pkg::CQF_ST_REPDISC;
      2'h2: beh_state = cqf_pkg::CQF_ST_SLEEP;
      default: beh_state = cqf_pkg::CQF_ST_IGNORE;
    endcase
  endfunction

  // Next state and whether the control pins are to be rechecked
  always_comb begin
    state_d = state_q;
    recheck = 1'b0;
    case (state_q)
      cqf_pkg::CQF_ST_NORMAL: begin
        // Behaviour changes here are silent; the new value is used at the hit
        // Level test: a hit that waits out an idle cycle still acts, and a same-cycle clear wins
        if (quota_hit_flag && active_state && !clr_pulse && !en_fall) begin
          state_d = beh_state(charge_quota_behavior_q);
        end
      end
      cqf_pkg::CQF_ST_IGNORE: begin
        if (beh_change) begin
          state_d = beh_state(beh_w);
        end
      end
      cqf_pkg::CQF_ST_REPORT: begin
        if (beh_change) begin
          state_d = beh_state(beh_w);
        end
      end
      cqf_pkg::CQF_ST_REPDISC: begin
        if (beh_change) begin
          state_d = beh_state(beh_w);
          recheck = (beh_w != 2'h2);
        end
      end
      cqf_pkg::CQF_ST_SLEEP: begin
        if (beh_change) begin
          state_d = beh_state(beh_w);
          recheck = 1'b1;
        end
      end
      default: begin
        state_d = cqf_pkg::CQF_ST_NORMAL;
      end
    endcase
    // Disable or clear after the hit returns to normal operation
    if (state_q != cqf_pkg::CQF_ST_NORMAL && (en_fall || clr_pulse)) begin
      state_d = cqf_pkg::CQF_ST_NORMAL;
      recheck = en_fall || state_q == cqf_pkg::CQF_ST_REPDISC || state_q == cqf_pkg::CQF_ST_SLEEP;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= cqf_pkg::CQF_ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Emulation restart
  // ****************************************
  logic removal_seen_q;
  logic restart_attach;
  logic restart_recheck;

  // Removal then attach while rationing below the limit restarts emulation
  always_ff @(posedge clk) begin
    if (reset) begin
      removal_seen_q <= 1'b0;
    end else if (removal_event) begin
      removal_seen_q <= 1'b1;
    end else if (attach_event) begin
      removal_seen_q <= 1'b0;
    end
  end

  assign restart_attach = attach_event && removal_seen_q && charge_quota_enable_q && !quota_hit_flag;
  // Unchanged pins mean a quiet return, no discharge and no restart
  assign restart_recheck = recheck && (ctl_now != ctl_snap_q) && emulation_enable;

  always_ff @(posedge clk) begin
    if (reset) begin
      emul_restart_q <= 1'b0;
    end else begin
      emul_restart_q <= restart_attach || restart_recheck;
    end
  end

  // ****************************************
  // Fault handling
  // ****************************************
  logic fault_any;
  logic latched_mode;

  assign fault_any = flt_over_current | flt_over_voltage | flt_under_voltage | flt_back_voltage
                   | flt_discharge | flt_over_temp;
  // Register bit governs when the bus is in use, pin otherwise
  assign latched_mode = smbus_in_use ? switch_cfg_q[`CQF_POS_LATCH_SET] : latch_pin;

  always_ff @(posedge clk) begin
    if (reset) begin
      fault_latched_mode_q <= 1'b0;
    end else begin
      fault_latched_mode_q <= latched_mode;
    end
  end

  // Latched holds until the host clears; auto follows the cause.
  // Retry timing lives outside; this flag only tells whether it may restore.
  always_ff @(posedge clk) begin
    if (reset) begin
      fault_q <= 1'b0;
    end else if (fault_any) begin
      fault_q <= 1'b1;
    end else if (!latched_mode || fault_clear) begin
      fault_q <= 1'b0;
    end
  end

  // ****************************************
  // Output drive
  // ****************************************
  logic quota_alert;
  logic quota_disconnect;

  // Report and Report+Disconnect both pull the alert
  function automatic logic state_alerts(input cqf_pkg::cqf_state_t s);
    state_alerts = (s == cqf_pkg::CQF_ST_REPORT) || (s == cqf_pkg::CQF_ST_REPDISC);
  endfunction

  // Both disconnecting states remove the profile and open the switch
  function automatic logic state_disconnects(input cqf_pkg::cqf_state_t s);
    state_disconnects = (s == cqf_pkg::CQF_ST_REPDISC) || (s == cqf_pkg::CQF_ST_SLEEP);
  endfunction

  assign quota_alert = state_alerts(state_d);
  assign quota_disconnect = state_disconnects(state_d);

  // Alert shared with faults; released only when neither holds it
  always_ff @(posedge clk) begin
    if (reset) begin
      alert_n_q <= 1'b1;
    end else begin
      alert_n_q <= !(quota_alert || fault_any || (fault_q && latched_mode));
    end
  end

  // Profile removal follows the applied state, not the register value
  always_ff @(posedge clk) begin
    if (reset) begin
      profile_remove_q <= 1'b0;
    end else begin
      profile_remove_q <= quota_disconnect;
    end
  end

  // Power switch stays open while a disconnecting behaviour holds
  always_ff @(posedge clk) begin
    if (reset) begin
      power_switch_open_q <= 1'b0;
    end else begin
      power_switch_open_q <= quota_disconnect;
    end
  end

  // Bypass kept off in Report+Disconnect, even if the detect pin asks for it
  always_ff @(posedge clk) begin
    if (reset) begin
      bypass_block_q <= 1'b0;
    end else begin
      bypass_block_q <= (state_d == cqf_pkg::CQF_ST_REPDISC);
    end
  end

  // Sleep request; control pins have no say until the quota is reset
  always_ff @(posedge clk) begin
    if (reset) begin
      sleep_req_q <= 1'b0;
    end else begin
      sleep_req_q <= (state_d == cqf_pkg::CQF_ST_SLEEP);
    end
  end
endmodule
`default_nettype wire

// [hw/placeholder_none.sv]
`default_nettype none
`default_nettype wire

// [verification/cqf_host_model.sv]
// Host model: register port writes and reads, and the power enable pin.
// Assumes one-cycle write strobes and read data one edge after the address.
`default_nettype none
module cqf_host_model (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output logic wr,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic ppe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Register port and pin tasks
  // ****************************************
  // Idle values before the first request
  initial begin
    wr = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    ppe = 1'b1;
  end
  // Data is inverted on release so a stale value never looks valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
    #1;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1;
    d = rdata;
  endtask
  // Power enable toggle, low for one cycle; the design only compares the pin at a recheck
  task automatic power_cycle();
    @(posedge clk);
    ppe <= 1'b0;
    @(posedge clk);
    ppe <= 1'b1;
    #1;
  endtask
endmodule
`default_nettype wire

// [verification/cqf_top_sva.sv]
// Checker for the charge quota and fault control top block.
// Assumes it is bound onto cqf_top and sees only that block's ports.
`include "cqf_consts.svh"
`default_nettype none
module cqf_top_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic attach_event,
  input wire logic smbus_in_use,
  input wire logic latch_pin,
  input wire logic fault_clear,
  input wire logic flt_over_current,
  input wire logic flt_over_voltage,
  input wire logic flt_under_voltage,
  input wire logic flt_back_voltage,
  input wire logic flt_discharge,
  input wire logic flt_over_temp,
  input wire logic alert_n_q,
  input wire logic profile_remove_q,
  input wire logic power_switch_open_q,
  input wire logic sleep_req_q,
  input wire logic emul_restart_q,
  input wire logic fault_latched_mode_q,
  input wire logic fault_q
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helpers and properties
  // ****************************************
  logic any_flt, quota_wr, normal_out, quiet;
  // Fault causes and quota writes, shared by several properties
  assign any_flt = flt_over_current | flt_over_voltage | flt_under_voltage | flt_back_voltage | flt_discharge
    | flt_over_temp;
  assign quota_wr = reg_wr && reg_addr == `CQF_OFS_QUOTA_CFG;
  assign normal_out = alert_n_q && !profile_remove_q && !power_switch_open_q && !sleep_req_q;
  assign quiet = !any_flt && !fault_q;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_FAULT_SET: assert property (any_flt |=> fault_q && !alert_n_q)
    else $error("fault cause did not raise fault");
  AST_AUTO_RECOVER: assert property (!fault_latched_mode_q && !any_flt |=> !fault_q)
    else $error("auto mode fault did not recover");
  AST_LATCH_HOLD: assert property (fault_latched_mode_q && fault_q && !fault_clear |=> fault_q)
    else $error("latched fault dropped without clear");
  AST_MODE_PIN: assert property (!smbus_in_use |=> fault_latched_mode_q == $past(latch_pin))
    else $error("fault mode does not follow pin");
  AST_CLEAR_NORMAL: assert property (quota_wr && reg_wdata[3] && quiet |=> normal_out)
    else $error("clear did not restore outputs");
  AST_DISABLE_NORMAL: assert property (quota_wr && !reg_wdata[2] && quiet |-> ##1 normal_out)
    else $error("disable did not restore outputs");
  AST_EMUL_CAUSE: assert property (emul_restart_q |-> $past(attach_event) || $past(quota_wr))
    else $error("emulation restart without cause");
  AST_SLEEP_OUT: assert property (sleep_req_q && !fault_q |->
    alert_n_q && profile_remove_q && power_switch_open_q)
    else $error("sleep outputs inconsistent");
endmodule
bind cqf_top cqf_top_sva i_cqf_top_sva (.*);
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the charge quota and fault control top block.
// Assumes the host model owns the register port and the power enable pin.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, active_state, charge_valid, attach_event, removal_event, mode_select_hi, emulation_enable;
  logic smbus_in_use, latch_pin, fault_clear, reg_wr, port_power_enable;
  logic [7:0] charge_amount, reg_addr, reg_wdata, reg_rdata_q;
  logic [5:0] flt;
  logic alert_n_q, profile_remove_q, power_switch_open_q, bypass_block_q, sleep_req_q, emul_restart_q;
  logic fault_latched_mode_q, fault_q;
  int fail_count = 0;
  int n_compared = 0;
  localparam logic [7:0] q_cfg = 8'h25;
  // Outputs per behaviour: alert_n, profile removed, switch open, sleep
  logic [3:0] beh_out [4] = '{4'h0, 4'h6, 4'hF, 4'h8};
  wire logic [3:0] outs = {alert_n_q, profile_remove_q, power_switch_open_q, sleep_req_q};
  // ****************************************
  // Design, host and clock
  // ****************************************
  cqf_top i_cqf_top (.*, .mode_select_lo(1'b0), .detect_feature_enable(1'b1), .flt_over_current(flt[0]),
    .flt_over_voltage(flt[1]), .flt_under_voltage(flt[2]), .flt_back_voltage(flt[3]), .flt_discharge(flt[4]),
    .flt_over_temp(flt[5]));
  cqf_host_model host (.clk, .rdata(reg_rdata_q), .wr(reg_wr), .addr(reg_addr), .wdata(reg_wdata),
    .ppe(port_power_enable));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic summarize();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic co(input logic [3:0] e);
    chk({4'h0, outs}, {4'h0, e});
  endtask
  task automatic cb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.read(a, v);
    chk(v, e);
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Charge lands next edge, flag one later, outputs one more
  task automatic charge(input logic [7:0] n);
    charge_valid <= 1'b1;
    charge_amount <= n;
    step(1);
    charge_valid <= 1'b0;
    step(3);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] a [8] = '{8'h17, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h30};
    logic [7:0] e [8] = '{8'h00, 8'h01, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};
    co(4'h8);
    for (int i = 0; i < 8; i++) begin
      rchk(a[i], e[i]);
    end
    host.write(8'h27, 8'h00);
    host.write(8'h28, 8'h10);
  endtask
  task automatic t_quota();
    for (int b = 0; b < 4; b++) begin
      host.write(q_cfg, 8'h0C | 8'(b));
      charge(8'h08);
      co(4'h8);
      rchk(8'h2A, 8'h08);
      charge(8'h08);
      co(beh_out[b]);
      rchk(8'h26, 8'h01);
      host.write(q_cfg, 8'h0C | 8'(b));
      co(4'h8);
      rchk(8'h2A, 8'h00);
    end
  endtask
  // Every old and new behaviour pair after the flag is set
  task automatic t_change();
    for (int o = 0; o < 4; o++) begin
      for (int n = 0; n < 4; n++) begin
        if (n != o) begin
          host.write(q_cfg, 8'h0C | 8'(n));
          charge(8'h08);
          host.write(q_cfg, 8'h04 | 8'(o));
          co(4'h8);
          charge(8'h08);
          co(beh_out[o]);
          host.write(q_cfg, 8'h04 | 8'(n));
          co(beh_out[n]);
          cb(bypass_block_q, n == 1);
          rchk(8'h2A, 8'h10);
        end
      end
    end
  endtask
  task automatic t_recheck();
    host.write(q_cfg, 8'h0D);
    charge(8'h10);
    host.write(q_cfg, 8'h07);
    cb(emul_restart_q, 1'b0);
    host.write(q_cfg, 8'h0D);
    charge(8'h10);
    mode_select_hi <= 1'b1;
    host.write(q_cfg, 8'h04);
    cb(emul_restart_q, 1'b1);
  endtask
  task automatic t_enable();
    host.write(q_cfg, 8'h0D);
    charge(8'h08);
    host.write(q_cfg, 8'h01);
    rchk(8'h2A, 8'h00);
    host.write(q_cfg, 8'h0D);
    charge(8'h10);
    host.write(q_cfg, 8'h01);
    co(4'h8);
    rchk(8'h26, 8'h00);
    host.power_cycle();
  endtask
  task automatic t_attach();
    active_state <= 1'b0;
    host.write(q_cfg, 8'h0D);
    charge(8'h10);
    rchk(8'h2A, 8'h00);
    active_state <= 1'b1;
    charge(8'h08);
    removal_event <= 1'b1;
    step(1);
    removal_event <= 1'b0;
    attach_event <= 1'b1;
    step(1);
    attach_event <= 1'b0;
    cb(emul_restart_q, 1'b1);
    rchk(8'h2A, 8'h08);
  endtask
  task automatic t_fault();
    for (int i = 0; i < 6; i++) begin
      flt <= 6'h01 << i;
      step(1);
      cb(alert_n_q, 1'b0);
      flt <= 6'h00;
      step(2);
      cb(fault_q, 1'b0);
    end
    latch_pin <= 1'b1;
    flt <= 6'h20;
    step(1);
    flt <= 6'h00;
    step(3);
    cb(fault_q, 1'b1);
    rchk(8'h26, 8'h02);
    fault_clear <= 1'b1;
    step(1);
    fault_clear <= 1'b0;
    step(1);
    cb(fault_q, 1'b0);
    smbus_in_use <= 1'b1;
    step(2);
    cb(fault_latched_mode_q, 1'b0);
    host.write(8'h17, 8'h01);
    step(1);
    cb(fault_latched_mode_q, 1'b1);
  endtask
  // Main sequence; reset is held for 16 edges
  initial begin
    reset = 1'b1;
    {active_state, emulation_enable} = 2'h3;
    {charge_valid, attach_event, removal_event, mode_select_hi, smbus_in_use, latch_pin, fault_clear} = 7'h00;
    charge_amount = 8'h00;
    flt = 6'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_quota();
    t_change();
    t_recheck();
    t_enable();
    t_attach();
    t_fault();
    summarize();
  end
  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
